/* hdl/gated_sixteen_bit_timer.v */
// Gated 16-bit up-counter with prescaler, clock source select, capture/compare
// time base and overflow interrupt/wake logic, reached over APB.
// Assumes one system clock; external pins are asynchronous and synchronised here.
// Byte loads are not buffered: stop the timer for a clean 16-bit load.
`timescale 1ns/1ps
`include "gated_timer_regs.vh"

module gated_sixteen_bit_timer #(
    parameter QUARTER_DIV = 4
) (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rst,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Pins and neighbours
    input  wire        extClockPin,
    input  wire        gatePin,
    input  wire        comparatorTwoOutput,
    input  wire        captureEvent,
    input  wire        sleepMode,
    // Results
    output reg         irqRequest,
    output reg         wakeRequest,
    output reg         vectorRequest,
    output reg         compareEvent,
    output reg         incrementTick,
    output reg         lowPowerOscOn
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg  [7:0]  timerOneControl;
    reg  [7:0]  countLowByte;
    reg  [7:0]  countHighByte;
    reg         overflowFlag;
    reg         overflowIrqEnable;
    reg         peripheralIrqEnable;
    reg         globalIrqEnable;
    reg  [15:0] capcmp;
    reg  [2:0]  ccMode;
    reg         gateSourceSelect;
    reg  [2:0]  prescaleCount;
    reg  [1:0]  quarterCount;
    // Pin synchronisers: the first stage feeds only the next stage, never any logic
    reg         extSync1;
    reg         extSync2;
    reg         extSync3;
    reg         extSync4;
    reg         gateSync1;
    reg         gateSync2;
    reg         cmpSync1;
    reg         cmpSync2;
    reg         capSync1;
    reg         capSync2;
    reg         capSync3;

    wire [15:0] count = {countHighByte, countLowByte};
    wire        runBit = timerOneControl[`CTL_RUN];
    wire        clkSrc = timerOneControl[`CTL_CLKSRC];
    wire        syncDis = timerOneControl[`CTL_SYNCDIS];
    wire [1:0]  prescaleSelect = timerOneControl[`CTL_PS_HI:`CTL_PS_LO];

    // ----------------------------------------
    // Clock source and gate
    // ----------------------------------------
    // The unsynchronised path still needs sampling here; it uses one stage
    // fewer of latency, so a trigger landing near its edge may be missed.
    wire extEdgeSync = extSync3 & ~extSync4;
    wire extEdgeAsync = extSync2 & ~extSync3;
    wire extEdge = syncDis ? extEdgeAsync : extEdgeSync;
    wire internalTick = (quarterCount == 2'd3);
    wire sourceTick = clkSrc ? extEdge : internalTick;
    // In sleep only the unsynchronised external path keeps counting
    wire sleepOk = ~sleepMode | (clkSrc & syncDis);
    // The gate is seen two clocks late, after its synchroniser
    wire gateSource = gateSourceSelect ? cmpSync2 : gateSync2;
    wire gateLevel = timerOneControl[`CTL_GATE_POL] ? gateSource : ~gateSource;
    // With gating off the gate level is ignored and counting is continuous
    wire gateOpen = ~timerOneControl[`CTL_GATE_EN] | gateLevel;
    wire countEnable = runBit & gateOpen & sleepOk;

    // The divider counts ticks of the selected source, not system clocks
    reg  prescaleDone;
    always @* begin
        case (prescaleSelect)
            2'd0:    prescaleDone = 1'b1;
            2'd1:    prescaleDone = (prescaleCount[0] == 1'b1);
            2'd2:    prescaleDone = (prescaleCount[1:0] == 2'd3);
            default: prescaleDone = (prescaleCount == 3'd7);
        endcase
    end
    wire increment = countEnable & sourceTick & prescaleDone;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // pready stands only in the access phase, so each write commits once
    wire access = psel & penable & pready;
    wire busWrite = access & pwrite;
    wire wrLow = busWrite & (paddr == `TMR_ADDR_COUNT_LO);
    wire wrHigh = busWrite & (paddr == `TMR_ADDR_COUNT_HI);
    wire wrIrq = busWrite & (paddr == `TMR_ADDR_IRQ);
    // Unmapped addresses answer with an error and match no write decode
    wire mapped = (paddr == `TMR_ADDR_CONTROL) |
                  (paddr == `TMR_ADDR_COUNT_LO) |
                  (paddr == `TMR_ADDR_COUNT_HI) |
                  (paddr == `TMR_ADDR_IRQ) |
                  (paddr == `TMR_ADDR_CAPCMP) |
                  (paddr == `TMR_ADDR_CCMODE) |
                  (paddr == `TMR_ADDR_AUX) |
                  (paddr == `TMR_ADDR_STATUS);

    wire match = ccMode[`CC_COMPARE_EN] & (capcmp == count);
    wire specialClear = match & ccMode[`CC_SPECIAL_EN];
    // Wrap comes only from an increment, so a special clear never sets the flag
    wire wrap = increment & (count == 16'hffff);
    wire captureHit = ccMode[`CC_CAPTURE_EN] & capSync2 & ~capSync3;

    // Byte writes first, then the special clear, then the increment; the
    // clear is lost when software loads a byte in the same cycle
    reg [15:0] next_count;
    always @* begin
        next_count = count;
        if (wrLow | wrHigh) begin
            if (wrLow)
                next_count[7:0] = pwdata[7:0];
            if (wrHigh)
                next_count[15:8] = pwdata[7:0];
        end else if (specialClear) begin
            next_count = 16'h0000;
        end else if (increment) begin
            next_count = count + 16'h0001;
        end
    end

    reg [31:0] next_prdata;
    always @* begin
        next_prdata = 32'h0000_0000;
        case (paddr)
            `TMR_ADDR_CONTROL:  next_prdata = {24'h000000, timerOneControl};
            `TMR_ADDR_COUNT_LO: next_prdata = {24'h000000, countLowByte};
            `TMR_ADDR_COUNT_HI: next_prdata = {24'h000000, countHighByte};
            `TMR_ADDR_IRQ:      next_prdata = {28'h0000000, globalIrqEnable,
                                     peripheralIrqEnable, overflowIrqEnable, overflowFlag};
            `TMR_ADDR_CAPCMP:   next_prdata = {16'h0000, capcmp};
            `TMR_ADDR_CCMODE:   next_prdata = {29'h00000000, ccMode};
            `TMR_ADDR_AUX:      next_prdata = {30'h00000000, gateSourceSelect, 1'b0};
            `TMR_ADDR_STATUS:   next_prdata = {30'h00000000, gateOpen, countEnable};
            default:            next_prdata = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------
    // Synchronisers and dividers
    // ----------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            extSync1 <= 1'b0;
            extSync2 <= 1'b0;
            extSync3 <= 1'b0;
            extSync4 <= 1'b0;
            gateSync1 <= 1'b0;
            gateSync2 <= 1'b0;
            cmpSync1 <= 1'b0;
            cmpSync2 <= 1'b0;
            capSync1 <= 1'b0;
            capSync2 <= 1'b0;
            capSync3 <= 1'b0;
            quarterCount <= 2'd0;
            prescaleCount <= 3'd0;
        end else begin
            extSync1 <= extClockPin;
            extSync2 <= extSync1;
            extSync3 <= extSync2;
            extSync4 <= extSync3;
            gateSync1 <= gatePin;
            gateSync2 <= gateSync1;
            cmpSync1 <= comparatorTwoOutput;
            cmpSync2 <= cmpSync1;
            capSync1 <= captureEvent;
            capSync2 <= capSync1;
            capSync3 <= capSync2;
            quarterCount <= quarterCount + 2'd1;
            // Restart when stopped so a new run begins with a full division
            if (!runBit)
                prescaleCount <= 3'd0;
            else if (countEnable & sourceTick)
                prescaleCount <= prescaleCount + 3'd1;
        end
    end

    // ----------------------------------------
    // Counter, flags and bus registers
    // ----------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            timerOneControl <= `CTL_RESET;
            countLowByte <= 8'h00;
            countHighByte <= 8'h00;
            overflowFlag <= 1'b0;
            overflowIrqEnable <= 1'b0;
            peripheralIrqEnable <= 1'b0;
            globalIrqEnable <= 1'b0;
            capcmp <= 16'h0000;
            ccMode <= 3'd0;
            gateSourceSelect <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            // A write setup loads zero, so an error answer never shows stale data
            if (psel & ~penable)
                prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            if (busWrite & (paddr == `TMR_ADDR_CONTROL))
                timerOneControl <= pwdata[7:0];
            if (busWrite & (paddr == `TMR_ADDR_CCMODE))
                ccMode <= pwdata[2:0];
            if (busWrite & (paddr == `TMR_ADDR_AUX))
                gateSourceSelect <= pwdata[`AUX_GATE_SRC];
            // Counter bytes take the value worked out above
            countLowByte <= next_count[7:0];
            countHighByte <= next_count[15:8];
            // A capture beats a bus write of the same register
            if (captureHit)
                capcmp <= count;
            else if (busWrite & (paddr == `TMR_ADDR_CAPCMP))
                capcmp <= pwdata[15:0];
            // A wrap in the clearing cycle keeps the flag set
            // Writing one raises the flag too, as a software-made interrupt
            if (wrap & ~(wrLow | wrHigh) & ~specialClear)
                overflowFlag <= 1'b1;
            else if (wrIrq)
                overflowFlag <= pwdata[`IRQ_FLAG];
            if (wrIrq) begin
                overflowIrqEnable <= pwdata[`IRQ_TIMER_EN];
                peripheralIrqEnable <= pwdata[`IRQ_PERIPH_EN];
                globalIrqEnable <= pwdata[`IRQ_GLOBAL_EN];
            end
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irqRequest <= 1'b0;
            wakeRequest <= 1'b0;
            vectorRequest <= 1'b0;
            compareEvent <= 1'b0;
            incrementTick <= 1'b0;
            lowPowerOscOn <= 1'b0;
        end else begin
            // Requests are levels; they drop once software clears the flag
            irqRequest <= overflowFlag & overflowIrqEnable &
                          peripheralIrqEnable & globalIrqEnable;
            wakeRequest <= sleepMode & overflowFlag & runBit &
                           overflowIrqEnable & peripheralIrqEnable;
            // After wake the core goes on; the vector only with global enable
            vectorRequest <= overflowFlag & overflowIrqEnable &
                             peripheralIrqEnable & globalIrqEnable & ~sleepMode;
            compareEvent <= match;
            incrementTick <= increment;
            // The oscillator lives outside; this only asks for it
            lowPowerOscOn <= timerOneControl[`CTL_OSCEN];
        end
    end

endmodule

/* hdl/gated_timer_regs.vh */
// Register offsets, field positions and reset values of the gated 16-bit timer.
// Included by the timer module; holds definitions only.
`ifndef GATED_TIMER_REGS_VH
`define GATED_TIMER_REGS_VH

// Byte addresses on the APB slave
`define TMR_ADDR_CONTROL   12'h000
`define TMR_ADDR_COUNT_LO  12'h004
`define TMR_ADDR_COUNT_HI  12'h008
`define TMR_ADDR_IRQ       12'h00c
`define TMR_ADDR_CAPCMP    12'h010
`define TMR_ADDR_CCMODE    12'h014
`define TMR_ADDR_AUX       12'h018
`define TMR_ADDR_STATUS    12'h01c

// Control register fields
`define CTL_RUN            0
`define CTL_CLKSRC         1
`define CTL_SYNCDIS        2
`define CTL_OSCEN          3
`define CTL_PS_LO          4
`define CTL_PS_HI          5
`define CTL_GATE_EN        6
`define CTL_GATE_POL       7
`define CTL_RESET          8'h00

// Interrupt register fields
`define IRQ_FLAG           0
`define IRQ_TIMER_EN       1
`define IRQ_PERIPH_EN      2
`define IRQ_GLOBAL_EN      3

// Capture/compare mode register fields
`define CC_CAPTURE_EN      0
`define CC_COMPARE_EN      1
`define CC_SPECIAL_EN      2

// Comparator auxiliary control fields
`define AUX_GATE_SRC       1

`endif

/* testbench/gated_sixteen_bit_timer_monitor.sv */
// Checker of the timer's ports: bus answer timing and request outputs.
// Assumes one clock ref_clk and the active-high asynchronous reset rst.
`timescale 1ns/1ps

module gated_sixteen_bit_timer_monitor #(
    parameter QUARTER_DIV = 4
) (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sleepMode,
    input wire logic        irqRequest,
    input wire logic        wakeRequest,
    input wire logic        vectorRequest,
    input wire logic        incrementTick
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_answer; psel && !penable |=> pready ##1 !pready; endproperty
    a_answer: assert property (p_answer) else $error("setup not answered in one cycle");
    property p_access; pready |-> psel && penable; endproperty
    a_access: assert property (p_access) else $error("ready outside access phase");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("error answer malformed");
    property p_vec; vectorRequest |-> irqRequest && !$past(sleepMode); endproperty
    a_vec: assert property (p_vec) else $error("vector without interrupt or while asleep");
    property p_wake; wakeRequest |-> $past(sleepMode); endproperty
    a_wake: assert property (p_wake) else $error("wake while awake");
    property p_excl; not (wakeRequest && vectorRequest); endproperty
    a_excl: assert property (p_excl) else $error("wake and vector together");
    property p_tick; incrementTick |=> !incrementTick; endproperty
    a_tick: assert property (p_tick) else $error("increment pulse too long");
    property p_reset; $fell(rst) |-> !pready && !irqRequest && !wakeRequest && !incrementTick;
    endproperty
    a_reset: assert property (p_reset) else $error("output active after reset");
endmodule

bind gated_sixteen_bit_timer gated_sixteen_bit_timer_monitor #(.QUARTER_DIV(QUARTER_DIV)) mon (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleepMode(sleepMode), .irqRequest(irqRequest),
    .wakeRequest(wakeRequest), .vectorRequest(vectorRequest), .incrementTick(incrementTick)
);

/* testbench/gated_sixteen_bit_timer_test.sv */
// Self-checking bench of the gated timer: APB tasks and directed sequences.
// Assumes the far-side model drives the pins; internal count is ref_clk/4.
`timescale 1ns/1ps
`include "gated_timer_regs.vh"

module gated_sixteen_bit_timer_test;
    logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        sleepMode = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr, extClockPin, gatePin, comparatorTwoOutput, captureEvent;
    wire         irqRequest, wakeRequest, vectorRequest, compareEvent, incrementTick;
    wire         lowPowerOscOn;
    int          failCount = 0, testsRun = 0, ticks = 0, events = 0, cyc = 0, t0;

    gated_sixteen_bit_timer uut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .extClockPin(extClockPin), .gatePin(gatePin),
        .comparatorTwoOutput(comparatorTwoOutput), .captureEvent(captureEvent),
        .sleepMode(sleepMode), .irqRequest(irqRequest), .wakeRequest(wakeRequest),
        .vectorRequest(vectorRequest), .compareEvent(compareEvent),
        .incrementTick(incrementTick), .lowPowerOscOn(lowPowerOscOn));
    gated_timer_far_side far (.ref_clk(ref_clk), .extClockPin(extClockPin), .gatePin(gatePin),
        .comparatorTwoOutput(comparatorTwoOutput), .captureEvent(captureEvent));

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        ticks <= ticks + (incrementTick === 1'b1);
        events <= events + (compareEvent === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failCount++;
            endOfTest();
        end
    end

    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge ref_clk) psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk) penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        testsRun++;
        if (g !== e) begin
            failCount++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        cmp(r, e);
    endtask
    task automatic run(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic setCount(input logic [7:0] hi, input logic [7:0] lo);
        wr(`TMR_ADDR_COUNT_LO, {24'h0, lo});
        wr(`TMR_ADDR_COUNT_HI, {24'h0, hi});
    endtask
    task endOfTest;
        $display("comparisons %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        run(5);
        rst <= 1'b0;
        chk(`TMR_ADDR_CONTROL, 32'h0);
        chk(12'h020, 32'h0);
        cmp(err, 1'b1);
        wr(`TMR_ADDR_CONTROL, 32'h08);
        run(3);
        cmp(lowPowerOscOn, 1'b1);
        chk(`TMR_ADDR_CONTROL, 32'h08);
        setCount(8'ha5, 8'h5a);
        run(20);
        chk(`TMR_ADDR_COUNT_LO, 32'h5a);
        chk(`TMR_ADDR_COUNT_HI, 32'ha5);
        // Odd passes also set the sync bit, which the internal source must ignore
        for (int p = 0; p < 4; p++) begin
            wr(`TMR_ADDR_CONTROL, 32'h01 | (p << 4) | ((p & 1) << 2));
            t0 = ticks;
            run(256);
            cmp((ticks - t0) >= (64 >> p) - 1 && (ticks - t0) <= (64 >> p) + 1, 1'b1);
        end
        // Selected source closed while the other is open, then the reverse
        for (int i = 0; i < 4; i++) begin
            wr(`TMR_ADDR_AUX, (i >> 1) << 1);
            wr(`TMR_ADDR_CONTROL, 32'h41 | ((i & 1) << 7));
            far.setGate((i > 1) ^ (i & 1) ^ 1, (i < 2) ^ (i & 1) ^ 1);
            run(8);
            t0 = ticks;
            run(64);
            cmp(ticks - t0, 0);
            far.setGate((i > 1) ^ (i & 1), (i < 2) ^ (i & 1));
            run(8);
            t0 = ticks;
            run(64);
            cmp(ticks - t0 >= 15, 1'b1);
        end
        wr(`TMR_ADDR_CONTROL, 32'h0);
        wr(`TMR_ADDR_IRQ, 32'h0);
        for (int k = 1; k < 4; k++) begin
            wr(`TMR_ADDR_IRQ, 32'hf ^ (1 << k));
            run(3);
            cmp(irqRequest, 1'b0);
        end
        wr(`TMR_ADDR_IRQ, 32'he);
        setCount(8'hff, 8'hfd);
        wr(`TMR_ADDR_CONTROL, 32'h01);
        run(40);
        cmp(irqRequest, 1'b1);
        cmp(vectorRequest, 1'b1);
        wr(`TMR_ADDR_CONTROL, 32'h0);
        chk(`TMR_ADDR_COUNT_HI, 32'h0);
        chk(`TMR_ADDR_IRQ, 32'hf);
        wr(`TMR_ADDR_IRQ, 32'h6);
        run(3);
        cmp(irqRequest, 1'b0);
        setCount(8'hff, 8'hfe);
        wr(`TMR_ADDR_CONTROL, 32'h07);
        sleepMode <= 1'b1;
        far.pulses(3);
        run(6);
        cmp(wakeRequest, 1'b1);
        cmp(vectorRequest, 1'b0);
        sleepMode <= 1'b0;
        wr(`TMR_ADDR_IRQ, 32'h0);
        setCount(8'h00, 8'h00);
        wr(`TMR_ADDR_CONTROL, 32'h03);
        far.pulses(5);
        run(8);
        wr(`TMR_ADDR_CONTROL, 32'h0);
        chk(`TMR_ADDR_COUNT_LO, 32'h05);
        wr(`TMR_ADDR_CCMODE, 32'h1);
        far.capture();
        run(6);
        chk(`TMR_ADDR_CAPCMP, 32'h05);
        wr(`TMR_ADDR_CCMODE, 32'h0);
        wr(`TMR_ADDR_CAPCMP, 32'd20);
        setCount(8'h00, 8'h00);
        wr(`TMR_ADDR_CCMODE, 32'h6);
        wr(`TMR_ADDR_CONTROL, 32'h01);
        t0 = events;
        run(400);
        cmp(events - t0 >= 3, 1'b1);
        wr(`TMR_ADDR_CONTROL, 32'h0);
        chk(`TMR_ADDR_COUNT_HI, 32'h0);
        chk(`TMR_ADDR_IRQ, 32'h0);
        endOfTest();
    end
endmodule

/* testbench/gated_timer_far_side.sv */
// Far-side model: external clock pin, gate pin, comparator output and capture source.
// Assumes the bench calls its tasks; all pins change just after a rising ref_clk edge.
`timescale 1ns/1ps

module gated_timer_far_side (
    // Clock
    input  wire logic ref_clk,
    // Pins towards the timer
    output logic      extClockPin,
    output logic      gatePin,
    output logic      comparatorTwoOutput,
    output logic      captureEvent
);
    initial begin
        extClockPin = 1'b0;
        gatePin = 1'b0;
        comparatorTwoOutput = 1'b0;
        captureEvent = 1'b0;
    end

    // Slow pulses so the four-flop sync never merges edges; pin idles low between bursts
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge ref_clk) extClockPin <= 1'b1;
            repeat (4) @(posedge ref_clk);
            extClockPin <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
    endtask

    task automatic setGate(input logic g, input logic c);
        @(posedge ref_clk) gatePin <= g;
        comparatorTwoOutput <= c;
    endtask

    task automatic capture;
        @(posedge ref_clk) captureEvent <= 1'b1;
        repeat (4) @(posedge ref_clk);
        captureEvent <= 1'b0;
    endtask
endmodule
